/* File: hw/low_voltage_detect_ctrl.sv */
// Low-voltage detect control, flag logic and APB register slave
//
// Behaviour
// - The enable bit powers the comparator and divider up while one and down while zero.
// - A read-only stable flag reads one only once the enabled reference is stable, and no flag is raised before.
// - After each enable the low-supply flag cannot be set until the reference start-up has ended.
// - The start-up interval is taken from the analog reference, not counted in system clocks.
// - A comparator trip at the chosen level sets the low-supply flag in the peripheral flag register.
// - A four-bit trip-level field in the low control bits drives the divider tap select.
// - Trip level all ones routes the external sense pin to the comparator instead of the divider.
// - Code 1110 is the highest internal level, 0010 the lowest, 0001 and 0000 are reserved.
// - Reset returns the control register to its reset state, turning the unit off.
// - The flag requests the interrupt vector only with its enable and the global enable both set.
// - The detector keeps working in sleep, and a trip there sets the flag and wakes the device.
`timescale 1ns/10ps
module low_voltage_detect_ctrl
    import lvd_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire apb_req_t     apb_req,
    output apb_rsp_t          apb_rsp,
    input  wire logic         reference_ready,
    input  wire logic         trip_detect,
    input  wire logic         sleep_active,
    output analog_ctrl_t      analog_ctrl,
    output logic              low_supply_irq_priority,
    output logic              vector_request,
    output logic              wake_request,
    output logic              irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_external(input logic [3:0] code);
        return code == LEVEL_EXTERNAL;
    endfunction

    function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    state_t s_reg;
    state_t s_next;

    logic        complete;
    logic        wr;
    logic        lane0;
    logic        trip_evt;
    logic        stable_rise;
    logic [7:0]  rdata;
    logic        unmapped;

    assign complete = apb_req.psel & apb_req.penable & s_reg.rsp.pready;
    assign wr       = complete & apb_req.pwrite;
    assign lane0    = apb_req.pstrb[0];

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata    = 8'h00;
        unmapped = 1'b0;
        if (hits(apb_req.paddr, OFS_DETECT_CONTROL))
        begin
            rdata = {2'b00, s_reg.stable, s_reg.en, s_reg.level};
        end
        else if (hits(apb_req.paddr, OFS_GLOBAL_CONTROL))
        begin
            rdata[BIT_GLOBAL_IE] = s_reg.gie;
        end
        else if (hits(apb_req.paddr, OFS_PRIORITY_TWO))
        begin
            rdata[BIT_LOW_SUPPLY] = s_reg.prio;
        end
        else if (hits(apb_req.paddr, OFS_FLAGS_TWO))
        begin
            rdata[BIT_LOW_SUPPLY] = s_reg.flag;
        end
        else if (hits(apb_req.paddr, OFS_ENABLES_TWO))
        begin
            rdata[BIT_LOW_SUPPLY] = s_reg.pie;
        end
        else if (hits(apb_req.paddr, OFS_EVENT_STATUS))
        begin
            rdata[1:0] = s_reg.evt;
        end
        else if (hits(apb_req.paddr, OFS_EVENT_MASK))
        begin
            rdata[1:0] = s_reg.evt_mask;
        end
        else
        begin
            unmapped = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;

        // Answer one cycle into the access phase so every response is a flop
        case (s_reg.apb)
            APB_IDLE:
            begin
                s_next.rsp.pready = 1'b0;
                if (apb_req.psel && apb_req.penable)
                begin
                    s_next.apb         = APB_READY;
                    s_next.rsp.pready  = 1'b1;
                    s_next.rsp.prdata  = {24'h000000, rdata};
                    s_next.rsp.pslverr = unmapped;
                end
            end
            APB_READY:
            begin
                s_next.apb         = APB_IDLE;
                s_next.rsp.pready  = 1'b0;
                s_next.rsp.prdata  = 32'h00000000;
                s_next.rsp.pslverr = 1'b0;
            end
            default:
            begin
                s_next.apb = APB_IDLE;
            end
        endcase

        // Register writes, low byte lane only; unmapped writes are dropped
        if (wr && lane0)
        begin
            if (hits(apb_req.paddr, OFS_DETECT_CONTROL))
            begin
                s_next.en    = apb_req.pwdata[BIT_ENABLE];
                s_next.level = apb_req.pwdata[3:0];
            end
            else if (hits(apb_req.paddr, OFS_GLOBAL_CONTROL))
            begin
                s_next.gie = apb_req.pwdata[BIT_GLOBAL_IE];
            end
            else if (hits(apb_req.paddr, OFS_PRIORITY_TWO))
            begin
                s_next.prio = apb_req.pwdata[BIT_LOW_SUPPLY];
            end
            else if (hits(apb_req.paddr, OFS_FLAGS_TWO))
            begin
                s_next.flag = apb_req.pwdata[BIT_LOW_SUPPLY];
            end
            else if (hits(apb_req.paddr, OFS_ENABLES_TWO))
            begin
                s_next.pie = apb_req.pwdata[BIT_LOW_SUPPLY];
            end
            else if (hits(apb_req.paddr, OFS_EVENT_STATUS))
            begin
                s_next.evt = s_reg.evt & ~apb_req.pwdata[1:0];
            end
            else if (hits(apb_req.paddr, OFS_EVENT_MASK))
            begin
                s_next.evt_mask = apb_req.pwdata[1:0];
            end
        end

        // Reference start-up is an analog interval; clock rate plays no part
        s_next.stable = s_next.en & s_reg.en & (s_reg.stable | reference_ready);

        // Hardware set beats a software clear in the same cycle
        trip_evt    = s_reg.en & s_reg.stable & trip_detect;
        stable_rise = s_next.stable & ~s_reg.stable;
        if (trip_evt)
        begin
            s_next.flag = 1'b1;
        end
        s_next.evt[BIT_EVT_TRIP]   = s_next.evt[BIT_EVT_TRIP] | trip_evt;
        s_next.evt[BIT_EVT_STABLE] = s_next.evt[BIT_EVT_STABLE] | stable_rise;

        s_next.ext_sel = is_external(s_next.level);
        s_next.irq     = |(s_next.evt & s_next.evt_mask);
        s_next.vector  = s_next.flag & s_next.pie & s_next.gie;
        s_next.wake    = s_next.flag & sleep_active;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg          <= '0;
            s_reg.apb      <= APB_IDLE;
            s_reg.level    <= RST_LEVEL;
            s_reg.evt      <= RST_EVT;
            s_reg.evt_mask <= RST_EVT;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign apb_rsp                           = s_reg.rsp;
    assign analog_ctrl = '{tap_select:            s_reg.level,
                           external_sense_select: s_reg.ext_sel,
                           detect_power_enable:   s_reg.en};
    assign low_supply_irq_priority           = s_reg.prio;
    assign vector_request                    = s_reg.vector;
    assign wake_request                      = s_reg.wake;
    assign irq                               = s_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Marks the first edge after reset release
    logic first_cycle;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_cycle <= 1'b1;
        end
        else
        begin
            first_cycle <= 1'b0;
        end
    end

    // Completed control write, low lane only
    logic ctrl_wr;
    assign ctrl_wr = wr && lane0 && hits(apb_req.paddr, OFS_DETECT_CONTROL);

    a_power_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> analog_ctrl.detect_power_enable == $past(apb_req.pwdata[BIT_ENABLE]))
        else $error("power enable does not follow control write");

    a_stable_needs_power: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.stable |-> analog_ctrl.detect_power_enable && $past(analog_ctrl.detect_power_enable))
        else $error("stable flag set without enable");

    a_flag_needs_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_reg.flag) && !$past(wr) |-> $past(s_reg.stable) && $past(trip_detect))
        else $error("flag set before reference stable");

    a_trip_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.en && s_reg.stable && trip_detect |=> s_reg.flag && s_reg.evt[BIT_EVT_TRIP])
        else $error("trip did not set flag");

    a_tap_and_external: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr && apb_req.pwdata[3:0] == LEVEL_EXTERNAL
        |=> analog_ctrl.external_sense_select && analog_ctrl.tap_select == LEVEL_EXTERNAL)
        else $error("external sense not selected");

    a_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
        first_cycle |-> !analog_ctrl.detect_power_enable && s_reg.level == RST_LEVEL)
        else $error("unit not off after reset");

    a_vector_gated: assert property (@(posedge pclk) disable iff (!presetn)
        vector_request |-> s_reg.flag && s_reg.pie && s_reg.gie)
        else $error("vector without both enables");

    a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.flag && sleep_active ##1 s_reg.flag |-> wake_request)
        else $error("no wake in sleep");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(s_reg.flag) |-> $past(wr) && !$past(apb_req.pwdata[BIT_LOW_SUPPLY]))
        else $error("flag cleared without software write");

    a_disable_unstable: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr && !apb_req.pwdata[BIT_ENABLE] |=> !s_reg.stable ##1 !s_reg.stable || s_reg.en)
        else $error("stable not cleared on disable");

    a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(s_reg.evt & s_reg.evt_mask))
        else $error("irq does not match status and mask");

    a_irq_needs_mask: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> |s_reg.evt_mask)
        else $error("irq with all events masked");

    a_stable_event: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_reg.stable) |-> s_reg.evt[BIT_EVT_STABLE])
        else $error("stable rise not recorded");

    a_stable_waits_ref: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_reg.stable) |-> $past(reference_ready))
        else $error("stable set without reference ready");

    a_level_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> analog_ctrl.tap_select == $past(apb_req.pwdata[3:0]))
        else $error("tap select does not follow control write");

    a_ext_sel_code: assert property (@(posedge pclk) disable iff (!presetn)
        analog_ctrl.external_sense_select == (analog_ctrl.tap_select == LEVEL_EXTERNAL))
        else $error("external select does not match level code");

    a_vector_sets: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg.flag && s_reg.pie && s_reg.gie |-> vector_request)
        else $error("vector missing with both enables");

    a_wake_in_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request |-> s_reg.flag && $past(sleep_active))
        else $error("wake without flag in sleep");

    a_flag_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && lane0 && hits(apb_req.paddr, OFS_FLAGS_TWO) && !apb_req.pwdata[BIT_LOW_SUPPLY]
        && !trip_evt |=> !s_reg.flag)
        else $error("flag not cleared by software write");

    a_off_no_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !analog_ctrl.detect_power_enable |-> !s_reg.stable)
        else $error("stable while powered down");

    a_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && lane0 && hits(apb_req.paddr, OFS_EVENT_STATUS) && apb_req.pwdata[BIT_EVT_TRIP]
        && !trip_evt |=> !s_reg.evt[BIT_EVT_TRIP])
        else $error("trip event not cleared");

    // ------------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------------
    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");

    a_pready_needs_access: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
        else $error("pready without access phase");

    a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");

    a_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.prdata[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");

endmodule // low_voltage_detect_ctrl

/* File: hw/lvd_pkg.sv */
// Package: register map, field layout and reset values of the low-voltage detect control
package lvd_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DETECT_CONTROL  = 8'h00;
    localparam logic [7:0] OFS_GLOBAL_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_PRIORITY_TWO    = 8'h08;
    localparam logic [7:0] OFS_FLAGS_TWO       = 8'h0C;
    localparam logic [7:0] OFS_ENABLES_TWO     = 8'h10;
    localparam logic [7:0] OFS_EVENT_STATUS    = 8'h14;
    localparam logic [7:0] OFS_EVENT_MASK      = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_STABLE     = 5;
    localparam int BIT_ENABLE     = 4;
    localparam int BIT_GLOBAL_IE  = 7;
    localparam int BIT_LOW_SUPPLY = 2;
    localparam int BIT_EVT_TRIP   = 0;
    localparam int BIT_EVT_STABLE = 1;

    // ------------------------------------------------------------------
    // Trip-level codes and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] LEVEL_EXTERNAL  = 4'hF;
    localparam logic [3:0] LEVEL_MAXIMUM   = 4'hE;
    localparam logic [3:0] LEVEL_MINIMUM   = 4'h2;
    localparam logic [3:0] LEVEL_RESERVED1 = 4'h1;
    localparam logic [3:0] LEVEL_RESERVED0 = 4'h0;
    localparam logic [3:0] RST_LEVEL       = 4'h5;
    localparam logic [1:0] RST_EVT         = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        APB_IDLE  = 1'b0,
        APB_READY = 1'b1
    } apb_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [3:0] tap_select;
        logic       external_sense_select;
        logic       detect_power_enable;
    } analog_ctrl_t;

    typedef struct packed {
        apb_state_t  apb;
        apb_rsp_t    rsp;
        logic [3:0]  level;
        logic        en;
        logic        stable;
        logic        ext_sel;
        logic        gie;
        logic        prio;
        logic        flag;
        logic        pie;
        logic [1:0]  evt;
        logic [1:0]  evt_mask;
        logic        irq;
        logic        vector;
        logic        wake;
    } state_t;

endpackage

/* File: verification/low_voltage_detect_ctrl_test.sv */
// Self-checking testbench of the low-voltage detect control
`timescale 1ns/10ps
module low_voltage_detect_ctrl_test;
    import lvd_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    apb_req_t     req;
    apb_rsp_t     rsp;
    analog_ctrl_t ac;
    logic         ready;
    logic         trip;
    logic         sleep = 1'b0;
    logic         slo = 1'b0;
    logic         elo = 1'b0;
    logic         prio;
    logic         vec;
    logic         wake;
    logic         irq;
    logic [31:0]  rdat;
    logic         rerr;
    int           fails = 0;
    int           num_checks = 0;
    int           cyc = 0;

    always #12.5 pclk = ~pclk;

    low_voltage_detect_ctrl uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .reference_ready(ready), .trip_detect(trip), .sleep_active(sleep), .analog_ctrl(ac),
        .low_supply_irq_priority(prio), .vector_request(vec), .wake_request(wake), .irq(irq));
    lvd_analog_model model (.pclk(pclk), .presetn(presetn), .ctrl(ac), .supply_low(slo),
        .ext_low(elo), .reference_ready(ready), .trip_detect(trip));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1)
            @(posedge pclk);
        chk(rsp.prdata[31:8], 0, "upper bytes");
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        xfer(1'b0, a, 32'h0);
        chk(rdat, e, m);
    endtask

    task automatic wait_stable(input logic [31:0] e);
        int n;
        n = 0;
        xfer(1'b0, OFS_DETECT_CONTROL, 32'h0);
        while (rdat[BIT_STABLE] !== 1'b1 && n < 40)
        begin
            xfer(1'b0, OFS_DETECT_CONTROL, 32'h0);
            n++;
        end
        chk(n < 40, 1, "never stable");
        chk(rdat, e, "stable ctrl");
    endtask

    task automatic trip_pulse();
        @(posedge pclk);
        slo <= 1'b1;
        repeat (3) @(negedge pclk);
        @(posedge pclk);
        slo <= 1'b0;
        repeat (3) @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(OFS_DETECT_CONTROL, 32'h05, "ctrl reset");
        chk(ac, {4'h5, 1'b0, 1'b0}, "analog reset");
        for (int i = 1; i < 7; i++)
            rd(8'(i * 4), 32'h0, "reg reset");
        rd(8'h1C, 32'h0, "unmapped");
        chk(rerr, 1, "unmapped err");
        $display("test reset done");
    endtask

    task automatic t_levels();
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, OFS_DETECT_CONTROL, 32'(i));
            @(negedge pclk);
            chk(ac.tap_select, 32'(i), "tap");
            chk(ac.external_sense_select, i == 15, "ext sel");
            chk(ac.detect_power_enable, 0, "power");
            rd(OFS_DETECT_CONTROL, 32'(i), "level back");
        end
        $display("test levels done");
    endtask

    task automatic t_startup();
        xfer(1'b1, OFS_DETECT_CONTROL, 32'h0E);
        xfer(1'b1, OFS_DETECT_CONTROL, 32'h1E);
        @(posedge pclk);
        slo <= 1'b1;
        @(negedge pclk);
        chk(ac.detect_power_enable, 1, "power on");
        rd(OFS_FLAGS_TWO, 32'h0, "flag in start-up");
        rd(OFS_DETECT_CONTROL, 32'h1E, "not yet stable");
        wait_stable(32'h3E);
        repeat (3) @(negedge pclk);
        rd(OFS_FLAGS_TWO, 32'h04, "flag set");
        @(posedge pclk);
        slo <= 1'b0;
        rd(OFS_FLAGS_TWO, 32'h04, "flag sticky");
        xfer(1'b1, OFS_FLAGS_TWO, 32'h0);
        rd(OFS_FLAGS_TWO, 32'h0, "flag cleared");
        $display("test startup done");
    endtask

    task automatic t_vector();
        trip_pulse();
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, OFS_GLOBAL_CONTROL, {24'h0, i[1], 7'h0});
            xfer(1'b1, OFS_ENABLES_TWO, {29'h0, i[0], 2'h0});
            repeat (2) @(negedge pclk);
            chk(vec, i == 3, "vector");
        end
        xfer(1'b1, OFS_PRIORITY_TWO, 32'h04);
        @(negedge pclk);
        chk(prio, 1, "priority");
        xfer(1'b1, OFS_ENABLES_TWO, 32'h0);
        xfer(1'b1, OFS_FLAGS_TWO, 32'h0);
        $display("test vector done");
    endtask

    task automatic t_sleep_irq();
        @(posedge pclk);
        sleep <= 1'b1;
        xfer(1'b1, OFS_EVENT_MASK, 32'h01);
        xfer(1'b1, OFS_EVENT_STATUS, 32'h03);
        chk({wake, irq}, 0, "idle");
        trip_pulse();
        chk({wake, irq}, 2'b11, "wake irq");
        rd(OFS_EVENT_STATUS, 32'h01, "status");
        xfer(1'b1, OFS_EVENT_MASK, 32'h0);
        repeat (2) @(negedge pclk);
        chk(irq, 0, "masked");
        xfer(1'b1, OFS_EVENT_STATUS, 32'h01);
        xfer(1'b1, OFS_EVENT_MASK, 32'h01);
        repeat (2) @(negedge pclk);
        chk(irq, 0, "status cleared");
        @(posedge pclk);
        sleep <= 1'b0;
        xfer(1'b1, OFS_FLAGS_TWO, 32'h0);
        $display("test sleep irq done");
    endtask

    task automatic t_external();
        xfer(1'b1, OFS_DETECT_CONTROL, 32'h0F);
        rd(OFS_DETECT_CONTROL, 32'h0F, "stable dropped");
        xfer(1'b1, OFS_DETECT_CONTROL, 32'h1F);
        rd(OFS_DETECT_CONTROL, 32'h1F, "restart");
        wait_stable(32'h3F);
        trip_pulse();
        rd(OFS_FLAGS_TWO, 32'h0, "divider ignored");
        @(posedge pclk);
        elo <= 1'b1;
        repeat (3) @(negedge pclk);
        rd(OFS_FLAGS_TWO, 32'h04, "external trip");
        @(posedge pclk);
        presetn <= 1'b0;
        elo <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_DETECT_CONTROL, 32'h05, "reset off");
        chk(ac.detect_power_enable, 0, "reset power");
        $display("test external done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            $display("unexpected at %0t: timeout", $time);
            complete_run();
        end
    end

    initial
    begin
        req = '0;
        req.pstrb = 4'hF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset();
        t_levels();
        t_startup();
        t_vector();
        t_sleep_irq();
        t_external();
        complete_run();
    end
endmodule // low_voltage_detect_ctrl_test

/* File: verification/lvd_analog_model.sv */
// Behavioural comparator, divider and reference facing the detect control
`timescale 1ns/10ps
module lvd_analog_model
    import lvd_pkg::*;
#(
    parameter int STARTUP = 20
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire analog_ctrl_t ctrl,
    input  wire logic         supply_low,
    input  wire logic         ext_low,
    output logic              reference_ready,
    output logic              trip_detect
);
    // ------------------------------------------------------------
    // Reference start-up
    // ------------------------------------------------------------
    // Stands in for a fixed analog time; restarts on every power-up
    int cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt <= 0;
        else if (!ctrl.detect_power_enable)
            cnt <= 0;
        else if (cnt < STARTUP)
            cnt <= cnt + 1;
    end
    assign reference_ready = ctrl.detect_power_enable && (cnt == STARTUP);
    // Powered comparator trips even before the reference settles
    assign trip_detect = ctrl.detect_power_enable &&
                         (ctrl.external_sense_select ? ext_low : supply_low);
endmodule // lvd_analog_model
